// ===== common/ctl_io_pkg.sv
package ctl_io_pkg;

    // *****************************************************
    // register map (word aligned byte addresses)
    // *****************************************************
    localparam logic [3:0] ctrl_offset    = 4'h0;
    localparam logic [3:0] status_offset  = 4'h4;
    localparam logic [3:0] user_offset    = 4'h8;

    // control register fields
    localparam int mode_lsb       = 0;
    localparam int late_fw_bit    = 2;
    localparam int copy_irq_en_bit = 3;

    // reset values
    localparam logic [1:0] mode_reset    = 2'h0;
    localparam logic       late_fw_reset = 1'h1;

    // bus answer: read data returned one cycle after the request is seen
    localparam int read_latency = 1;

    // *****************************************************
    // types
    // *****************************************************
    typedef enum logic [1:0] {
        mode_user_pair,
        mode_user_disable,
        mode_user_disable4,
        mode_ext_test
    } input_mode_t;

    // decoded internal functions of the four control inputs
    typedef struct packed {
        logic next_pulse;
        logic user_a;
        logic user_b;
        logic counter_reset;
        logic advance_inhibit;
        logic count_disable;
        logic ext_test;
    } route_t;

    // status coming from the scaler core for lines 5..8
    typedef struct packed {
        logic copy_in_progress;
        logic fifo_empty;
        logic fifo_half;
        logic fifo_full;
    } core_status_t;

    typedef enum logic [1:0] {
        bus_idle,
        bus_answer
    } bus_state_t;

endpackage

// ===== rtl/control_io_mode_mux.sv
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module control_io_mode_mux (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // avalon-mm slave
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    // front panel control inputs 1..4 and outputs 5..8
    input  wire logic [3:0]                 ctl_in,
    output logic      [3:0]                 ctl_out,
    // scaler core side
    input  wire ctl_io_pkg::core_status_t   core_status,
    output logic                            next_strobe,
    output logic                            reset_strobe,
    output logic                            line_advance_event,
    output logic                            advance_inhibit,
    output logic                            count_disable,
    output logic                            ext_test,
    output logic                            user_flag_a,
    output logic                            user_flag_b,
    output logic                            copy_irq_pulse
);

    // *****************************************************
    // input synchronisation
    // *****************************************************
    logic [3:0] in_level;
    logic [3:0] in_rise;

    input_sync #(
        .width (4)
    ) input_sync_inst (
        .clk       (clk),
        .resetn    (resetn),
        .raw_in    (ctl_in),
        .level_out (in_level),
        .rise_out  (in_rise)
    );

    // *****************************************************
    // registers
    // *****************************************************
    logic [1:0]                 mode_r;
    logic [1:0]                 mode_nxt;
    logic                       late_fw_r;
    logic                       late_fw_nxt;
    logic                       irq_en_r;
    logic                       irq_en_nxt;
    ctl_io_pkg::bus_state_t     bus_r;
    ctl_io_pkg::bus_state_t     bus_nxt;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    logic                       wait_r;
    logic                       wait_nxt;

    // *****************************************************
    // routing decode
    // *****************************************************
    ctl_io_pkg::route_t route;

    always_comb
    begin
        route            = '0;
        route.next_pulse = in_rise[0];
        route.user_a     = in_level[1];
        case (ctl_io_pkg::input_mode_t'(mode_r))
            ctl_io_pkg::mode_user_pair:
            begin
                route.user_b = in_level[2];
                if (late_fw_r)
                    route.advance_inhibit = in_level[3];
                else
                    route.counter_reset = in_rise[3];
            end
            ctl_io_pkg::mode_user_disable:
            begin
                route.count_disable = in_level[2];
                if (late_fw_r)
                    route.advance_inhibit = in_level[3];
                else
                    route.counter_reset = in_rise[3];
            end
            ctl_io_pkg::mode_user_disable4:
            begin
                route.user_b        = in_level[2];
                route.count_disable = in_level[3];
            end
            ctl_io_pkg::mode_ext_test:
            begin
                route.next_pulse = 1'b0;
                route.user_a     = 1'b0;
                route.ext_test   = in_level[3];
            end
            default:
            begin
                route = '0;
            end
        endcase
    end

    // *****************************************************
    // core facing outputs
    // *****************************************************
    logic       ua_nxt;
    logic       ub_nxt;
    logic       copy_last_r;
    logic       advance_nxt;

    // user bits captured at next pulse leading edge
    always_comb
    begin
        ua_nxt = user_flag_a;
        ub_nxt = user_flag_b;
        if (route.next_pulse)
        begin
            ua_nxt = route.user_a;
            ub_nxt = route.user_b;
        end
        // inhibit suppresses the advance, the raw next strobe still passes
        advance_nxt = route.next_pulse & ~route.advance_inhibit;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            next_strobe        <= 1'b0;
            reset_strobe       <= 1'b0;
            line_advance_event <= 1'b0;
            advance_inhibit    <= 1'b0;
            count_disable      <= 1'b0;
            ext_test           <= 1'b0;
            user_flag_a        <= 1'b0;
            user_flag_b        <= 1'b0;
            ctl_out            <= 4'h0;
            copy_last_r        <= 1'b0;
            copy_irq_pulse     <= 1'b0;
        end
        else
        begin
            next_strobe        <= route.next_pulse;
            reset_strobe       <= route.counter_reset;
            line_advance_event <= advance_nxt;
            advance_inhibit    <= route.advance_inhibit;
            count_disable      <= route.count_disable;
            ext_test           <= route.ext_test;
            user_flag_a        <= ua_nxt;
            user_flag_b        <= ub_nxt;
            ctl_out            <= {core_status.fifo_full, core_status.fifo_half,
                                   core_status.fifo_empty, core_status.copy_in_progress};
            copy_last_r        <= core_status.copy_in_progress;
            copy_irq_pulse     <= irq_en_r & core_status.copy_in_progress & ~copy_last_r;
        end
    end

    // *****************************************************
    // avalon-mm slave
    // *****************************************************
    // waitrequest is high idle; one answer cycle drops it for a single edge
    always_comb
    begin
        mode_nxt    = mode_r;
        late_fw_nxt = late_fw_r;
        irq_en_nxt  = irq_en_r;
        bus_nxt     = bus_r;
        rdata_nxt   = rdata_r;
        wait_nxt    = 1'b1;
        case (bus_r)
            ctl_io_pkg::bus_idle:
            begin
                if (avs_read || avs_write)
                begin
                    bus_nxt  = ctl_io_pkg::bus_answer;
                    wait_nxt = 1'b0;
                    rdata_nxt = 32'h0;
                    if (avs_read)
                    begin
                        case (avs_address)
                            ctl_io_pkg::ctrl_offset:
                            begin
                                rdata_nxt[ctl_io_pkg::mode_lsb +: 2]       = mode_r;
                                rdata_nxt[ctl_io_pkg::late_fw_bit]         = late_fw_r;
                                rdata_nxt[ctl_io_pkg::copy_irq_en_bit]     = irq_en_r;
                            end
                            ctl_io_pkg::status_offset:
                                rdata_nxt[3:0] = in_level;
                            ctl_io_pkg::user_offset:
                                rdata_nxt[1:0] = {user_flag_b, user_flag_a};
                            default:
                                rdata_nxt = 32'h0;
                        endcase
                    end
                end
            end
            ctl_io_pkg::bus_answer:
            begin
                // the write takes effect at the edge where waitrequest is low
                if (avs_write && avs_address == ctl_io_pkg::ctrl_offset)
                begin
                    mode_nxt    = avs_writedata[ctl_io_pkg::mode_lsb +: 2];
                    late_fw_nxt = avs_writedata[ctl_io_pkg::late_fw_bit];
                    irq_en_nxt  = avs_writedata[ctl_io_pkg::copy_irq_en_bit];
                end
                bus_nxt = ctl_io_pkg::bus_idle;
            end
            default:
                bus_nxt = ctl_io_pkg::bus_idle;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mode_r    <= ctl_io_pkg::mode_reset;
            late_fw_r <= ctl_io_pkg::late_fw_reset;
            irq_en_r  <= 1'b0;
            bus_r     <= ctl_io_pkg::bus_idle;
            rdata_r   <= 32'h0;
            wait_r    <= 1'b1;
        end
        else
        begin
            mode_r    <= mode_nxt;
            late_fw_r <= late_fw_nxt;
            irq_en_r  <= irq_en_nxt;
            bus_r     <= bus_nxt;
            rdata_r   <= rdata_nxt;
            wait_r    <= wait_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // *****************************************************
    // assertions
    // *****************************************************
    // a next pulse leading edge outside test mode
    sequence next_rise_s;
        in_rise[0] && mode_r != 2'h3;
    endsequence

    user_capture_a: assert property (@(posedge clk) disable iff (!resetn)
        next_rise_s |=> user_flag_a == $past(in_level[1]))
        else $error("user flag a not captured");
    count_disable_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode_r == 2'h2 && in_level[3]) |=> count_disable)
        else $error("count disable missing");
    ext_test_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode_r == 2'h3) |=> !next_strobe)
        else $error("next strobe in test mode");
    inhibit_lne_a: assert property (@(posedge clk) disable iff (!resetn)
        (late_fw_r && mode_r[1] == 1'b0 && in_level[3]) |=> !line_advance_event)
        else $error("advance not inhibited");
    early_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        (!late_fw_r && mode_r == 2'h0 && in_rise[3]) |=> reset_strobe)
        else $error("reset strobe missing");
    copy_line_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> ctl_out[0] == $past(core_status.copy_in_progress))
        else $error("copy line wrong");
    full_line_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> ctl_out[3] == $past(core_status.fifo_full))
        else $error("full line wrong");
    // enabled single pulse; enable seen one edge before the pulse
    copy_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        copy_irq_pulse |-> $past(irq_en_r) ##1 !copy_irq_pulse)
        else $error("irq pulse too long");
    reset_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        reset_strobe |=> !reset_strobe)
        else $error("reset strobe not single");

endmodule
`default_nettype wire

// ===== rtl/input_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser with rising edge strobe on the second stage output
module input_sync #(
    parameter int width = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // raw and synchronised levels, rising edge strobes
    input  wire logic [width-1:0] raw_in,
    output logic      [width-1:0] level_out,
    output logic      [width-1:0] rise_out
);

    logic [width-1:0] meta_r;
    logic [width-1:0] meta_nxt;
    logic [width-1:0] sync_r;
    logic [width-1:0] sync_nxt;
    logic [width-1:0] last_r;
    logic [width-1:0] last_nxt;

    // first stage only feeds the second one
    always_comb
    begin
        meta_nxt = raw_in;
        sync_nxt = meta_r;
        last_nxt = sync_r;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
        end
    end

    assign level_out = sync_r;
    assign rise_out  = sync_r & ~last_r;

endmodule
`default_nettype wire

// ===== tb/panel_partner.sv
`timescale 1ns/1ns
`default_nettype none
// external trigger hardware: holds the levels it is told, adds a clean next pulse
module panel_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // requests from the bench
    input  wire logic [3:0] levels,
    input  wire logic       pulse_go,
    // panel side
    output logic      [3:0] ctl_in,
    output logic            busy
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;

    // pulse sequencer; user levels stay put for one cycle before and two cycles after the pulse
    // setup and hold
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (pulse_go && cnt_r == 3'h0)
            cnt_nxt = 3'h6;
        else if (cnt_r != 3'h0)
            cnt_nxt = cnt_r - 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            cnt_r <= 3'h0;
        else
            cnt_r <= cnt_nxt;
    end

    // levels held as long as asked
    assign busy   = (cnt_r != 3'h0);
    assign ctl_in = {levels[3:1], levels[0] | (cnt_r >= 3'h3 && cnt_r <= 3'h5)};
endmodule
`default_nettype wire

// ===== tb/test_control_io_mode_mux.sv
`timescale 1ns/1ns
`default_nettype none
module test_control_io_mode_mux;
    // ****************************************
    // signals
    // ****************************************
    logic                     clk;
    logic                     resetn;
    logic [3:0]               avs_address;
    logic                     avs_read;
    logic                     avs_write;
    logic [31:0]              avs_writedata;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    logic [3:0]               ctl_in;
    logic [3:0]               ctl_out;
    ctl_io_pkg::core_status_t core_status;
    logic                     next_strobe;
    logic                     reset_strobe;
    logic                     line_advance_event;
    logic                     advance_inhibit;
    logic                     count_disable;
    logic                     ext_test;
    logic                     user_flag_a;
    logic                     user_flag_b;
    logic                     copy_irq_pulse;
    logic [3:0]               levels;
    logic                     pulse_go;
    logic                     busy;
    int                       err_total;
    int                       total_checks;
    int                       n_next;
    int                       n_rst;
    int                       n_lae;
    int                       n_irq;

    control_io_mode_mux control_io_mode_mux_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ctl_in(ctl_in), .ctl_out(ctl_out), .core_status(core_status),
        .next_strobe(next_strobe), .reset_strobe(reset_strobe), .line_advance_event(line_advance_event),
        .advance_inhibit(advance_inhibit), .count_disable(count_disable), .ext_test(ext_test),
        .user_flag_a(user_flag_a), .user_flag_b(user_flag_b), .copy_irq_pulse(copy_irq_pulse));

    panel_partner panel_partner_inst (.clk(clk), .resetn(resetn), .levels(levels), .pulse_go(pulse_go),
        .ctl_in(ctl_in), .busy(busy));

    // ****************************************
    // clock, pulse counters, watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // strobes are one cycle wide, so counting them catches doubles and misses
    always @(posedge clk)
    begin
        n_next <= n_next + int'(next_strobe === 1'b1);
        n_rst  <= n_rst + int'(reset_strobe === 1'b1);
        n_lae  <= n_lae + int'(line_advance_event === 1'b1);
        n_irq  <= n_irq + int'(copy_irq_pulse === 1'b1);
    end

    // whole run is well under 2000 cycles; this is ten times that
    initial
    begin
        #200000;
        err_total++;
        conclude();
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // hold the request until waitrequest is sampled low, then release
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic bus_rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin : main
        int m;
        int lf;
        int s_rst;
        int s_next;
        int s_lae;
        int s_irq;
        logic ua;
        logic ub;
        logic exp_b;
        logic [31:0] cfg;
        avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
        core_status = '0; levels = 4'h0; pulse_go = 1'b0; resetn = 1'b0;
        err_total = 0; total_checks = 0; n_next = 0; n_rst = 0; n_lae = 0; n_irq = 0;
        cyc(2);
        resetn <= 1'b1;
        bus_rd_chk("ctrl reset", ctl_io_pkg::ctrl_offset, 32'h4);
        bus_wr(4'hc, 32'hff);
        bus_rd_chk("unmapped", 4'hc, 32'h0);
        bus_rd_chk("ctrl after unmapped write", ctl_io_pkg::ctrl_offset, 32'h4);
        // status lines, with the copy interrupt enabled then disabled
        for (int e = 1; e >= 0; e--)
        begin
            bus_wr(ctl_io_pkg::ctrl_offset, 32'h4 | (e << ctl_io_pkg::copy_irq_en_bit));
            s_irq = n_irq;
            for (int i = 0; i < 4; i++)
            begin
                core_status <= 4'h8 >> i;
                cyc(4);
                chk("ctl_out", 4'h1 << i, ctl_out);
            end
            core_status <= '0;
            cyc(3);
            chk("irq count", e, n_irq - s_irq);
        end
        // every mode on both firmware generations
        for (m = 0; m < 4; m++)
        begin
            for (lf = 0; lf < 2; lf++)
            begin
                ua = lf[0];
                ub = ~lf[0];
                exp_b = (m == 1) ? 1'b0 : ub;
                levels <= 4'h0;
                cyc(8);
                chk("disable released", 1'b0, count_disable);
                cfg = 32'(m) | 32'(lf << ctl_io_pkg::late_fw_bit);
                bus_wr(ctl_io_pkg::ctrl_offset, cfg);
                bus_rd_chk("ctrl", ctl_io_pkg::ctrl_offset, cfg);
                s_rst = n_rst;
                levels <= {1'b1, ub, ua, 1'b0};
                cyc(8);
                chk("count_disable", (m == 1) ? ub : (m == 2), count_disable);
                chk("advance_inhibit", (m < 2) && lf == 1, advance_inhibit);
                chk("ext_test", m == 3, ext_test);
                chk("reset count", (m < 2) && lf == 0, n_rst - s_rst);
                bus_rd_chk("input levels", ctl_io_pkg::status_offset, {28'h0, 1'b1, ub, ua, 1'b0});
                // the partner must be idle before it is asked for another pulse
                while (busy === 1'b1)
                    @(posedge clk);
                s_next = n_next;
                s_lae = n_lae;
                pulse_go <= 1'b1;
                @(posedge clk);
                pulse_go <= 1'b0;
                cyc(10);
                chk("next count", m != 3, n_next - s_next);
                chk("advance count", m != 3 && !((m < 2) && lf == 1), n_lae - s_lae);
                if (m != 3)
                begin
                    chk("user a", ua, user_flag_a);
                    chk("user b", exp_b, user_flag_b);
                    bus_rd_chk("user flags", ctl_io_pkg::user_offset, {30'h0, exp_b, ua});
                end
            end
        end
        // second reset in mid run: registers return to their reset values
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        bus_rd_chk("ctrl after second reset", ctl_io_pkg::ctrl_offset, 32'h4);
        chk("ext_test after reset", 1'b0, ext_test);
        cyc(4);
        chk("inhibit after reset", 1'b1, advance_inhibit);
        conclude();
    end
endmodule
`default_nettype wire
